// ### dv/flash_model.sv
// serial flash model holding personality images for every slot
module flash_model (
	// serial flash pins
	input  wire logic        flashCs_n,
	input  wire logic        flashSck,
	input  wire logic        flashMosi,
	output logic             flashMiso,
	// read observation
	output logic [23:0]      readAddr,
	output logic [7:0]       readCount
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] shift = '0;
	logic [7:0]  cur;
	int          bits = 0;
	function automatic logic [7:0] imageByte(input logic [23:0] a);
		logic [3:0]  s;
		logic [23:0] o;
		logic [31:0] sz;
		s = (a < 24'h1e0000) ? 4'(a / 24'h030000 + 1) : 4'((a - 24'h1e0000) / 24'h002000 + 11);
		o = (a < 24'h1e0000) ? a % 24'h030000 : (a - 24'h1e0000) % 24'h002000;
		sz = (s <= 4'ha && s[0]) ? 32'h00001000 + 32'(s) : 32'h00001000;
		if (o == 24'h0) return {4'h0, s};
		if (o < 24'h4) return 8'ha0 + 8'(o);
		if (o < 24'h1a) return (o - 24'h4 < 24'(s)) ? 8'h41 : 8'h00;
		// reserved policy bits set so a decoder that reads them goes wrong
		if (o == 24'h1a) return {6'h3f, s[1:0]};
		if (o == 24'h1b) return 8'h50 + 8'(s);
		if (o >= 24'h20 && o < 24'h24) return 8'(sz >> (8 * (o - 24'h20)));
		if (o >= 24'h1000) return 8'h5a ^ o[7:0];
		return 8'hff;
	endfunction
	initial begin
		flashMiso = 1'b0;
		readAddr = '0;
		readCount = '0;
	end
	always @(negedge flashCs_n) bits = 0;
	// a released line never keeps its last bit, so stale reads show up
	always @(posedge flashCs_n) flashMiso = ~flashMiso;
	always @(posedge flashSck) begin
		if (!flashCs_n) begin
			shift = {shift[30:0], flashMosi};
			bits++;
			if (bits == 32 && shift[31:24] == 8'h03) begin
				readAddr = shift[23:0];
				readCount++;
			end
		end
	end
	always @(negedge flashSck) begin
		if (!flashCs_n && bits >= 32) begin
			cur = imageByte(readAddr + 24'((bits - 32) / 8));
			flashMiso = cur[3'(7 - (bits - 32) % 8)];
		end
	end
endmodule

// ### dv/tb.sv
// testbench for the personality slot loader
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_n = 0, loadStart = 0, execDone = 0;
	logic        linkClk = 0, linkCs_n = 1, linkMosi = 0;
	logic [3:0]  slotIndex = 0, cmdSource, cmdDest;
	logic [7:0]  buttonPress = 0, cfgData, cmdOp, readCount, revision, cfgSum = 0;
	logic        loadBusy, loadError, loaded, flashCs_n, flashSck, flashMosi, flashMiso;
	logic        cfgErase, cfgStrobe, execStart, halted, cmdValid, cmdReject, ok;
	logic [31:0] personalityId, imageSize;
	logic [4:0]  nameLength;
	logic [1:0]  policy, execKind, cmdAddrSize;
	logic [23:0] execAddr, readAddr;
	logic [9:0]  execLen;
	logic [2:0]  cmdCount;
	logic [23:0] addrQ[$];
	int          failCount = 0, compares = 0, cycles = 0, erases = 0, strobes = 0;
	int          starts = 0, valids = 0, rejects = 0, v0, r0;
	logic [3:0]  slots[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hf, 4'hc};
	// the first command carries opcode 0x30, count 3, address size 3
	logic [23:0] cmds[6] = '{24'h303385, 24'h244008, 24'h200100, 24'h215011,
		24'h221009, 24'h231090};

	personality_slot_loader i_personality_slot_loader (.clk, .rst_n, .loadStart, .slotIndex,
		.loadBusy, .loadError, .loaded, .personalityId, .nameLength, .policy, .revision,
		.imageSize, .flashCs_n, .flashSck, .flashMosi, .flashMiso, .cfgErase, .cfgStrobe,
		.cfgData, .buttonPress, .execDone, .execStart, .execAddr, .execLen, .execKind,
		.halted, .linkClk, .linkCs_n, .linkMosi, .cmdValid, .cmdReject, .cmdOp, .cmdAddrSize,
		.cmdCount, .cmdSource, .cmdDest);
	flash_model i_flash_model (.flashCs_n, .flashSck, .flashMosi, .flashMiso, .readAddr,
		.readCount);

	always #50 clk = ~clk;
	always @(readCount) addrQ.push_back(readAddr);
	// pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge clk) begin
		if (cfgErase === 1'b1) erases++;
		if (cfgStrobe === 1'b1) cfgSum ^= cfgData;
		if (cfgStrobe === 1'b1) strobes++;
		if (execStart === 1'b1) starts++;
		if (cmdValid === 1'b1) valids++;
		if (cmdReject === 1'b1) rejects++;
		cycles++;
		// nine loads of about 2600 cycles each fit well under this ceiling
		if (cycles == 60000) begin
			failCount++;
			results();
		end
	end

	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		compares++;
		if (got !== exp) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic doLoad(input logic [3:0] s);
		logic [1:0]  p;
		logic        e;
		logic [23:0] b;
		logic [7:0]  x;
		int          n, s0;
		p = s[1:0];
		e = s == 4'h0 || (s > 4'ha && p[0]);
		b = s > 4'ha ? 24'h1e0000 + 24'(s - 4'hb) * 24'h2000 : 24'(s - 4'h1) * 24'h30000;
		n = (s <= 4'ha && s[0]) ? int'(s) : 0;
		x = 8'h00;
		for (int i = 0; i < n; i++) x ^= 8'h5a ^ 8'(i);
		erases = 0;
		strobes = 0;
		cfgSum = 0;
		s0 = starts;
		addrQ.delete();
		@(negedge clk);
		loadStart = 1'b1;
		slotIndex = s;
		@(negedge clk);
		loadStart = 1'b0;
		for (int i = 0; i < 30000 && loadBusy !== 1'b0; i++) @(negedge clk);
		repeat (4) @(negedge clk);
		check("loadError", e, loadError);
		check("erase", !e && !p[1], erases);
		check("strobes", n, strobes);
		check("cfgData", x, cfgSum);
		check("setup starts", !e, starts - s0);
		if (!e) begin
			check("flash addr", b, addrQ[0]);
			if (n > 0) check("cfg addr", b + 24'h1000, addrQ[1]);
			check("id", {24'ha3a2a1, 4'h0, s}, personalityId);
			check("name", s, nameLength);
			check("policy", p, policy);
			check("revision", 8'h50 + s, revision);
			check("size", 32'h1000 + n, imageSize);
			check("setup", {b + 24'h100, 10'h200, 2'h0}, {execAddr, execLen, execKind});
			check("loaded", 1'b1, loaded);
		end
		$display("test load slot %0d done", s);
	endtask

	task automatic step(input logic [23:0] a, input logic [1:0] k, input int want);
		int s0;
		s0 = starts;
		@(negedge clk);
		execDone = 1'b1;
		@(negedge clk);
		execDone = 1'b0;
		repeat (4) @(negedge clk);
		check("starts", want, starts - s0);
		if (want) check("section", {a, 10'h100, k}, {execAddr, execLen, execKind});
	endtask

	task automatic frame(input logic [23:0] d, input int n);
		linkCs_n = 1'b0;
		for (int i = 0; i < 8 * n; i++) begin
			linkMosi = d[23 - i];
			#40 linkClk = 1'b1;
			#40 linkClk = 1'b0;
		end
		#40 linkCs_n = 1'b1;
		linkMosi = ~linkMosi;
		repeat (12) @(negedge clk);
	endtask

	initial begin
		// link reset passes through link flops, so its clock runs during reset
		fork
			repeat (12) @(negedge clk);
			#13 repeat (4) begin
				#40 linkClk = 1'b1;
				#40 linkClk = 1'b0;
			end
		join
		rst_n = 1'b1;
		// link reset leaves through two link flops: idle link clocks before any frame
		repeat (3) begin
			#40 linkClk = 1'b1;
			#40 linkClk = 1'b0;
		end
		repeat (3) @(negedge clk);
		foreach (slots[i]) doLoad(slots[i]);
		buttonPress = 8'h85;
		@(negedge clk);
		buttonPress = 8'h00;
		step(24'h1e2500, 2'h2, 1);
		step(24'h1e2700, 2'h2, 1);
		step(24'h1e2c00, 2'h2, 1);
		step(24'h1e2300, 2'h1, 1);
		step(24'h1e2300, 2'h1, 1);
		$display("test sections done");
		foreach (cmds[i]) begin
			v0 = valids;
			r0 = rejects;
			frame(cmds[i], 3);
			ok = cmds[i][14:12] inside {[1:4]} && cmds[i][3:0] <= 8 && cmds[i][7:4] <= 8;
			check("valid", ok, valids - v0);
			check("reject", !ok, rejects - r0);
			if (ok) check("fields", {cmds[i][23:16], cmds[i][9:8], cmds[i][14:12],
				cmds[i][3:0], cmds[i][7:4]}, {cmdOp, cmdAddrSize, cmdCount, cmdSource,
				cmdDest});
		end
		$display("test link done");
		frame(24'h7f0000, 1);
		check("halted", 1'b1, halted);
		buttonPress = 8'h01;
		@(negedge clk);
		buttonPress = 8'h00;
		step(24'h0, 2'h0, 0);
		doLoad(4'h1);
		check("halt cleared", 1'b0, halted);
		$display("test halt done");
		results();
	end
endmodule

// ### hw/personality_slot_loader.sv
// personality slot loader: flash reader, logic-device configuration, section scheduler
// How it works
// - fifteen slots, one chosen by index and loaded when a load is requested
// - slots one to ten are 192K apart from address zero, may configure
// - slots eleven to fifteen are 8K each from 0x1E0000, never configure
// - image bytes zero to three form the personality identifier
// - the 22-byte name is a null-terminated string; its length is reported
// - policy bits 1:0 at 0x1A choose erase, erase+program, untouched, program
// - revision byte at 0x1B is shown but never gates loading
// - size field at 0x20 gives image length; 4096 means no logic image
// - reserved bytes are skipped, never interpreted
// - setup section runs once at load, after configuration when it applies
// - background section restarts continuously while the personality is active
// - interrupt section is left unexecuted
// - eight button sections from 0x500, each run on its button press
// - configuration image from 0x1000, at most 188K, sent when policy programs
// - configuration bytes leave on the test port toward the logic device
// - forwarded commands arrive on the serial link and are decoded and checked here
// - register address size takes 0 to 3 bytes; zero means no address
// - data byte count accepted only from 1 to 4
// - write source is entry field 0-7 or the fixed value
// - read destination is return field 0-7 or the autonomous field
// - halt stops all further setup, button, interrupt and background sections until the next load request
module personality_slot_loader (
	// system
	input  wire logic        clk,
	input  wire logic        rst_n,
	// load control
	input  wire logic        loadStart,
	input  wire logic [3:0]  slotIndex,
	output logic             loadBusy,
	output logic             loadError,
	output logic             loaded,
	// image header
	output logic [31:0]      personalityId,
	output logic [4:0]       nameLength,
	output logic [1:0]       policy,
	output logic [7:0]       revision,
	output logic [31:0]      imageSize,
	// serial flash
	output logic             flashCs_n,
	output logic             flashSck,
	output logic             flashMosi,
	input  wire logic        flashMiso,
	// test port toward the logic device
	output logic             cfgErase,
	output logic             cfgStrobe,
	output logic [7:0]       cfgData,
	// section execution
	input  wire logic [7:0]  buttonPress,
	input  wire logic        execDone,
	output logic             execStart,
	output logic [23:0]      execAddr,
	output logic [9:0]       execLen,
	output logic [1:0]       execKind,
	output logic             halted,
	// forwarded command link
	input  wire logic        linkClk,
	input  wire logic        linkCs_n,
	input  wire logic        linkMosi,
	output logic             cmdValid,
	output logic             cmdReject,
	output logic [7:0]       cmdOp,
	output logic [1:0]       cmdAddrSize,
	output logic [2:0]       cmdCount,
	output logic [3:0]       cmdSource,
	output logic [3:0]       cmdDest
);
	slot_loader_pkg::state_t state;
	logic [23:0] slotBase;
	logic        smallSlot;
	logic [3:0]  slotSeen;
	logic        rdStart;
	logic        rdRun;
	logic [31:0] rdShift;
	logic [7:0]  rdIn;
	logic [1:0]  sckDiv;
	logic [4:0]  bitCnt;
	logic        addrPhase;
	logic        byteStb;
	logic [7:0]  rdByte;
	logic [23:0] rdAddr;
	logic        misoMeta;
	logic        misoSync;
	logic [5:0]  hdrIdx;
	logic        nameEnded;
	logic [17:0] cfgLeft;
	logic [7:0]  buttonPend;
	logic        execBusy;

	// slot index to flash address
	function automatic logic [23:0] slot_base(input logic [3:0] idx);
		if (idx <= slot_loader_pkg::LARGE_LAST) begin
			slot_base = slot_loader_pkg::LARGE_BASE
				+ 24'(idx - slot_loader_pkg::SLOT_FIRST) * slot_loader_pkg::LARGE_STRIDE;
		end else begin
			slot_base = slot_loader_pkg::SMALL_BASE
				+ 24'(idx - slot_loader_pkg::LARGE_LAST - 4'h1)
				* slot_loader_pkg::SMALL_STRIDE;
		end
	endfunction

	// flash data pin crosses in by two flops
	always_ff @(posedge clk) begin
		misoMeta <= flashMiso;
		misoSync <= misoMeta;
	end

	// serial flash read engine, mode 0; sampling at the falling edge leaves the
	// synchroniser six cycles of settled data after the flash shifts
	always_ff @(posedge clk) begin
		byteStb <= 1'b0;
		if (!rst_n || !rdRun) begin
			flashSck  <= 1'b0;
			flashCs_n <= 1'b1;
			flashMosi <= 1'b0;
			sckDiv    <= 2'h0;
			bitCnt    <= 5'h0;
			addrPhase <= 1'b1;
			rdShift   <= 32'h0;
			rdIn      <= 8'h0;
			rdByte    <= 8'h0;
		end else if (rdStart) begin
			flashCs_n <= 1'b0;
			rdShift   <= {slot_loader_pkg::FLASH_READ, rdAddr};
			flashMosi <= slot_loader_pkg::FLASH_READ[7];
			sckDiv    <= 2'h0;
			bitCnt    <= 5'h0;
			addrPhase <= 1'b1;
		end else if (sckDiv == slot_loader_pkg::SCK_HALF_CYC) begin
			sckDiv   <= 2'h0;
			flashSck <= ~flashSck;
			if (flashSck) begin
				rdShift   <= {rdShift[30:0], 1'b0};
				flashMosi <= rdShift[30];
				bitCnt    <= bitCnt + 5'h1;
				if (addrPhase) begin
					if (bitCnt == 5'h1f) begin
						addrPhase <= 1'b0;
						bitCnt    <= 5'h0;
					end
				end else begin
					rdIn <= {rdIn[6:0], misoSync};
					if (bitCnt[2:0] == 3'h7) begin
						rdByte  <= {rdIn[6:0], misoSync};
						byteStb <= 1'b1;
					end
				end
			end
		end else begin
			sckDiv <= sckDiv + 2'h1;
		end
	end

	// load sequence
	always_ff @(posedge clk) begin
		rdStart  <= 1'b0;
		cfgErase <= 1'b0;
		cfgStrobe <= 1'b0;
		if (!rst_n) begin
			state         <= slot_loader_pkg::ST_IDLE;
			rdRun         <= 1'b0;
			rdAddr        <= 24'h0;
			slotBase      <= 24'h0;
			smallSlot     <= 1'b0;
			slotSeen      <= 4'h0;
			hdrIdx        <= 6'h0;
			nameEnded     <= 1'b0;
			cfgLeft       <= 18'h0;
			cfgData       <= 8'h0;
			loadBusy      <= 1'b0;
			loadError     <= 1'b0;
			loaded        <= 1'b0;
			personalityId <= 32'h0;
			nameLength    <= 5'h0;
			policy        <= 2'h0;
			revision      <= 8'h0;
			imageSize     <= 32'h0;
		end else begin
			unique case (state)
				slot_loader_pkg::ST_IDLE, slot_loader_pkg::ST_ACTIVE,
				slot_loader_pkg::ST_FAULT: begin
					if (loadStart) begin
						loaded    <= 1'b0;
						slotSeen  <= slotIndex;
						if (slotIndex < slot_loader_pkg::SLOT_FIRST) begin
							loadError <= 1'b1;
							state     <= slot_loader_pkg::ST_FAULT;
						end else begin
							loadError <= 1'b0;
							loadBusy  <= 1'b1;
							slotBase  <= slot_base(slotIndex);
							rdAddr    <= slot_base(slotIndex);
							smallSlot <= slotIndex > slot_loader_pkg::LARGE_LAST;
							rdRun     <= 1'b1;
							rdStart   <= 1'b1;
							hdrIdx    <= 6'h0;
							nameEnded <= 1'b0;
							nameLength <= 5'h0;
							state     <= slot_loader_pkg::ST_HEADER;
						end
					end
				end
				slot_loader_pkg::ST_HEADER: begin
					if (byteStb) begin
						hdrIdx <= hdrIdx + 6'h1;
						// only the named header bytes are kept
						if (hdrIdx <= slot_loader_pkg::OFS_ID + 6'h3) begin
							personalityId[8*hdrIdx[1:0] +: 8] <= rdByte;
						end
						if (hdrIdx >= slot_loader_pkg::OFS_NAME && !nameEnded
							&& hdrIdx < slot_loader_pkg::OFS_POLICY) begin
							if (rdByte == 8'h00) begin
								nameEnded <= 1'b1;
							end else begin
								nameLength <= 5'(hdrIdx - slot_loader_pkg::OFS_NAME) + 5'h1;
							end
						end
						if (hdrIdx == slot_loader_pkg::OFS_POLICY) begin
							policy <= rdByte[1:0];
						end
						if (hdrIdx == slot_loader_pkg::OFS_REV) begin
							revision <= rdByte;
						end
						if (hdrIdx >= slot_loader_pkg::OFS_SIZE) begin
							imageSize[8*hdrIdx[1:0] +: 8] <= rdByte;
						end
						if (hdrIdx == slot_loader_pkg::HDR_LAST) begin
							rdRun <= 1'b0;
							state <= slot_loader_pkg::ST_DECIDE;
						end
					end
				end
				slot_loader_pkg::ST_DECIDE: begin
					if (policy[0] && smallSlot) begin
						loadError <= 1'b1;
						loadBusy  <= 1'b0;
						state     <= slot_loader_pkg::ST_FAULT;
					end else begin
						cfgErase <= !policy[1];
						if (policy[0] && imageSize > slot_loader_pkg::SIZE_NO_CFG) begin
							rdAddr  <= slotBase + slot_loader_pkg::OFS_CONFIG;
							cfgLeft <= (imageSize - slot_loader_pkg::SIZE_NO_CFG
								> 32'(slot_loader_pkg::CONFIG_MAX))
								? slot_loader_pkg::CONFIG_MAX
								: 18'(imageSize - slot_loader_pkg::SIZE_NO_CFG);
							rdRun   <= 1'b1;
							rdStart <= 1'b1;
							state   <= slot_loader_pkg::ST_CONFIG;
						end else begin
							state <= slot_loader_pkg::ST_SETUP;
						end
					end
				end
				slot_loader_pkg::ST_CONFIG: begin
					if (byteStb) begin
						cfgData   <= rdByte;
						cfgStrobe <= 1'b1;
						cfgLeft   <= cfgLeft - 18'h1;
						if (cfgLeft == 18'h1) begin
							rdRun <= 1'b0;
							state <= slot_loader_pkg::ST_SETUP;
						end
					end
				end
				slot_loader_pkg::ST_SETUP: begin
					loadBusy <= 1'b0;
					loaded   <= 1'b1;
					state    <= slot_loader_pkg::ST_ACTIVE;
				end
			endcase
		end
	end

	// section scheduler; a press in the cycle its section starts is kept
	always_ff @(posedge clk) begin
		execStart <= 1'b0;
		if (!rst_n) begin
			buttonPend <= 8'h0;
			execBusy   <= 1'b0;
			execAddr   <= 24'h0;
			execLen    <= 10'h0;
			execKind   <= 2'h0;
		end else if (state == slot_loader_pkg::ST_SETUP) begin
			buttonPend <= 8'h0;
			execStart  <= !halted;
			execBusy   <= !halted;
			execAddr   <= slotBase + slot_loader_pkg::OFS_SETUP;
			execLen    <= slot_loader_pkg::SETUP_LEN;
			execKind   <= slot_loader_pkg::SEC_SETUP;
		end else if (state != slot_loader_pkg::ST_ACTIVE) begin
			buttonPend <= 8'h0;
			execBusy   <= 1'b0;
		end else begin
			buttonPend <= buttonPend | buttonPress;
			if (execBusy) begin
				execBusy <= !execDone;
			end else if (!halted) begin
				execStart <= 1'b1;
				execBusy  <= 1'b1;
				execLen   <= slot_loader_pkg::SECTION_LEN;
				// interrupt section is never issued
				if (buttonPend != 8'h0) begin
					for (int b = 7; b >= 0; b--) begin
						if (buttonPend[b]) begin
							execAddr <= slotBase + slot_loader_pkg::OFS_BUTTON
								+ 24'(b) * slot_loader_pkg::BUTTON_STEP;
						end
					end
					buttonPend <= (buttonPend & (buttonPend - 8'h1)) | buttonPress;
					execKind   <= slot_loader_pkg::SEC_BUTTON;
				end else begin
					execAddr <= slotBase + slot_loader_pkg::OFS_BACK;
					execKind <= slot_loader_pkg::SEC_BACK;
				end
			end
		end
	end

	// link domain: reset level crosses in, bytes cross out by toggle
	logic       linkRstMeta;
	logic       linkRst_n;
	logic [2:0] linkBit;
	logic [6:0] linkShift;
	logic [7:0] linkByte;
	logic       linkToggle;

	always_ff @(posedge linkClk) begin
		linkRstMeta <= rst_n;
		linkRst_n   <= linkRstMeta;
	end

	// frames are whole bytes; the byte stays put for eight link clocks
	always_ff @(posedge linkClk) begin
		if (!linkRst_n || linkCs_n) begin
			linkBit <= 3'h0;
		end else begin
			linkBit   <= linkBit + 3'h1;
			linkShift <= {linkShift[5:0], linkMosi};
		end
	end

	always_ff @(posedge linkClk) begin
		if (!linkRst_n) begin
			linkByte   <= 8'h0;
			linkToggle <= 1'b0;
		end else if (!linkCs_n && linkBit == 3'h7) begin
			linkByte   <= {linkShift, linkMosi};
			linkToggle <= ~linkToggle;
		end
	end

	logic       togMeta;
	logic       togSync;
	logic       togSeen;
	logic       csMeta;
	logic       csSync;
	logic [1:0] cmdPos;
	logic [7:0] hold0;
	logic [7:0] hold1;

	always_ff @(posedge clk) begin
		togMeta <= linkToggle;
		togSync <= togMeta;
		csMeta  <= linkCs_n;
		csSync  <= csMeta;
	end

	// three-byte commands: opcode, {count, size}, {destination, source}
	always_ff @(posedge clk) begin
		cmdValid  <= 1'b0;
		cmdReject <= 1'b0;
		if (!rst_n) begin
			togSeen     <= 1'b0;
			cmdPos      <= 2'h0;
			hold0       <= 8'h0;
			hold1       <= 8'h0;
			halted      <= 1'b0;
			cmdOp       <= 8'h0;
			cmdAddrSize <= 2'h0;
			cmdCount    <= 3'h0;
			cmdSource   <= 4'h0;
			cmdDest     <= 4'h0;
		end else begin
			togSeen <= togSync;
			if (loadStart) begin
				halted <= 1'b0;
			end
			if (csSync && togSync == togSeen) begin
				cmdPos <= 2'h0;
			end else if (togSync != togSeen) begin
				unique case (cmdPos)
					2'h0: begin
						hold0  <= linkByte;
						cmdPos <= 2'h1;
						if (linkByte == slot_loader_pkg::OP_HALT) begin
							halted <= 1'b1;
							cmdPos <= 2'h0;
						end
					end
					2'h1: begin
						hold1  <= linkByte;
						cmdPos <= 2'h2;
					end
					default: begin
						cmdPos      <= 2'h0;
						cmdOp       <= hold0;
						cmdAddrSize <= hold1[1:0];
						cmdCount    <= hold1[6:4];
						cmdSource   <= linkByte[3:0];
						cmdDest     <= linkByte[7:4];
						if (hold1[6:4] == 3'h0 || hold1[6:4] > slot_loader_pkg::COUNT_MAX
							|| linkByte[3:0] > slot_loader_pkg::SRC_FIXED
							|| linkByte[7:4] > slot_loader_pkg::DST_AUTO) begin
							cmdReject <= 1'b1;
						end else begin
							cmdValid <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// checks
	slot_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		rdStart && state == slot_loader_pkg::ST_HEADER && !smallSlot
		|-> rdAddr == 24'(slotSeen - 4'h1) * slot_loader_pkg::LARGE_STRIDE)
		else $error("large slot base wrong");
	small_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == slot_loader_pkg::ST_HEADER && smallSlot
		|-> slotBase == slot_loader_pkg::SMALL_BASE
		+ 24'(slotSeen - 4'hb) * slot_loader_pkg::SMALL_STRIDE)
		else $error("small slot base wrong");
	small_prog_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == slot_loader_pkg::ST_DECIDE && policy[0] && smallSlot
		|=> state == slot_loader_pkg::ST_FAULT && loadError && !cfgErase)
		else $error("small slot programmed");
	bad_slot_a: assert property (@(posedge clk) disable iff (!rst_n)
		loadStart && slotIndex == 4'h0 && !loadBusy |=> loadError && !rdRun)
		else $error("slot zero accepted");
	erase_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == slot_loader_pkg::ST_DECIDE && !(policy[0] && smallSlot)
		|=> cfgErase == !policy[1])
		else $error("erase policy wrong");
	no_cfg_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfgStrobe |-> policy[0] && !smallSlot)
		else $error("configuration without program policy");
	setup_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == slot_loader_pkg::ST_SETUP && !halted
		|=> execStart && execKind == slot_loader_pkg::SEC_SETUP && !cfgStrobe)
		else $error("setup not started after load");
	halt_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
		halted && $past(halted) |-> !execStart)
		else $error("section run while halted");
	count_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmdValid |-> cmdCount >= 3'h1 && cmdCount <= 3'h4 && cmdSource <= 4'h8)
		else $error("bad command accepted");
	back_run_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == slot_loader_pkg::ST_ACTIVE && execBusy && execDone && !halted
		&& buttonPend == 8'h0 && buttonPress == 8'h0
		|=> ##1 execStart && execKind == slot_loader_pkg::SEC_BACK)
		else $error("background not restarted");
	load_cov: cover property (@(posedge clk) disable iff (!rst_n)
		state == slot_loader_pkg::ST_CONFIG ##[1:1000] execStart);
	button_cov: cover property (@(posedge clk) disable iff (!rst_n)
		execStart && execKind == slot_loader_pkg::SEC_BUTTON);
	cmd_cov: cover property (@(posedge clk) disable iff (!rst_n) cmdValid);
	fault_cov: cover property (@(posedge clk) disable iff (!rst_n)
		state == slot_loader_pkg::ST_FAULT);
endmodule

// ### hw/slot_loader_pkg.sv
// constants, codes and types shared by the personality slot loader
package slot_loader_pkg;
	// slot map in the serial flash
	localparam logic [3:0]  SLOT_FIRST   = 4'h1;
	localparam logic [3:0]  SLOT_LAST    = 4'hf;
	localparam logic [3:0]  LARGE_LAST   = 4'ha;
	localparam logic [23:0] LARGE_BASE   = 24'h000000;
	localparam logic [23:0] LARGE_STRIDE = 24'h030000;
	localparam logic [23:0] SMALL_BASE   = 24'h1e0000;
	localparam logic [23:0] SMALL_STRIDE = 24'h002000;
	// image layout
	localparam logic [5:0]  OFS_ID       = 6'h00;
	localparam logic [5:0]  OFS_NAME     = 6'h04;
	localparam logic [4:0]  NAME_LEN     = 5'h16;
	localparam logic [5:0]  OFS_POLICY   = 6'h1a;
	localparam logic [5:0]  OFS_REV      = 6'h1b;
	localparam logic [5:0]  OFS_SIZE     = 6'h20;
	localparam logic [5:0]  HDR_LAST     = 6'h23;
	localparam logic [23:0] OFS_SETUP    = 24'h000100;
	localparam logic [9:0]  SETUP_LEN    = 10'h200;
	localparam logic [23:0] OFS_BACK     = 24'h000300;
	localparam logic [23:0] OFS_INTR     = 24'h000400;
	localparam logic [23:0] OFS_BUTTON   = 24'h000500;
	localparam logic [23:0] BUTTON_STEP  = 24'h000100;
	localparam logic [9:0]  SECTION_LEN  = 10'h100;
	localparam logic [23:0] OFS_CONFIG   = 24'h001000;
	localparam logic [31:0] SIZE_NO_CFG  = 32'h00001000;
	localparam logic [17:0] CONFIG_MAX   = 18'h2f000;
	// flash command and serial timing
	localparam logic [7:0]  FLASH_READ   = 8'h03;
	localparam int          CLK_NS       = 100;
	localparam int          SCK_HALF_NS  = 400;
	localparam logic [1:0]  SCK_HALF_CYC = 2'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS - 1);
	// forwarded command fields
	localparam logic [7:0]  OP_HALT      = 8'h7f;
	localparam logic [2:0]  COUNT_MAX    = 3'h4;
	localparam logic [3:0]  SRC_FIXED    = 4'h8;
	localparam logic [3:0]  DST_AUTO     = 4'h8;

	typedef enum logic [1:0] {
		POL_ERASE      = 2'h0,
		POL_ERASE_PROG = 2'h1,
		POL_KEEP       = 2'h2,
		POL_PROG       = 2'h3
	} policy_t;

	typedef enum logic [1:0] {
		SEC_SETUP  = 2'h0,
		SEC_BACK   = 2'h1,
		SEC_BUTTON = 2'h2
	} section_t;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_HEADER = 7'h02,
		ST_DECIDE = 7'h04,
		ST_CONFIG = 7'h08,
		ST_SETUP  = 7'h10,
		ST_ACTIVE = 7'h20,
		ST_FAULT  = 7'h40
	} state_t;
endpackage
